// ===== hw/sram_cfg_defines.svh
// Timing counts, field positions and reset values for the configuration link.
`ifndef SRAM_CFG_DEFINES_SVH
`define SRAM_CFG_DEFINES_SVH
`define REF_MHZ       200
`define LINK_MHZ      (`REF_MHZ / 2)
`define RSH_CYC       400000
`define TSH_US        200
`define TSH_CYC       (`TSH_US * `LINK_MHZ)
`define PLL_US        100
`define PLL_CYC       (`PLL_US * `LINK_MHZ)
`define CFGH_PLL_US   100
`define CFGH_PLL_CYC  (`CFGH_PLL_US * `LINK_MHZ)
`define CFGS_CYC      32
`define CFGH_CYC      32
`define CFGH_ODT_CYC  4096
`define CFGD_CYC      80
`define CLDS_CYC      32
`define CLDH_CYC      32
`define CFGA_CYC      16
`define CLDW_CYC      16
`define CRDL_CYC      32
`define CRDH_CYC      32
`define RD_LAT_CYC    8
`define RD_HOLD_CYC   4
`define DEV_RST_CYC   16
`define CNT_W         20
`define ADDR_W        8
`define CFG_W         8
`define DQ_W          18
`define REG_NUM       8
`define ODT_IDX       8'h01
`define PLL_IDX       8'h02
`define CFG_REG_RST   8'h00
`endif

// ===== hw/sram_cfg_pkg.sv
// Types shared by both ends of the configuration link.
package sram_cfg_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ENTER = 3'h1,
        ST_SETUP = 3'h3,
        ST_LOAD  = 3'h2,
        ST_HOLD  = 3'h6,
        ST_EXIT  = 3'h7
    } ctl_state_e;
endpackage : sram_cfg_pkg

// ===== hw/sram_cfg_if.sv
// Interface joining the memory controller end and the memory device end.
`timescale 1ns/1ps
`include "sram_cfg_defines.svh"
interface sram_cfg_if;
    logic                link_clk;
    logic                dev_rst_n;
    logic                jtag_rst_n;
    logic                cfg_n;
    logic                port_a_load_n;
    logic                port_a_rw_n;
    logic [`ADDR_W-1:0]  addr;
    logic [`DQ_W-1:0]    ctl_dq_out;
    logic                ctl_dq_oe;
    logic [`DQ_W-1:0]    dev_dq_out;
    logic                dev_dq_oe;
    logic                port_a_read_valid;
    logic [`DQ_W-1:0]    port_b_data;
    logic [`DQ_W-1:0]    port_a_data;

    // Shared data wire: whichever end enables its driver sets the level; the controller wins if both do.
    assign port_a_data = ctl_dq_oe ? ctl_dq_out : (dev_dq_oe ? dev_dq_out : '0);

    modport ctl (output link_clk, dev_rst_n, jtag_rst_n, cfg_n, port_a_load_n,
                 port_a_rw_n, addr, ctl_dq_out, ctl_dq_oe,
                 input port_a_data, port_a_read_valid, port_b_data);
    modport dev (input link_clk, dev_rst_n, jtag_rst_n, cfg_n, port_a_load_n,
                 port_a_rw_n, addr, port_a_data,
                 output dev_dq_out, dev_dq_oe, port_a_read_valid, port_b_data);
endinterface : sram_cfg_if

// ===== hw/sram_cfg_device.sv
// Memory device end: configuration registers, read timing and lock timer.
`timescale 1ns/1ps
`include "sram_cfg_defines.svh"
module sram_cfg_device
    import sram_cfg_pkg::*;
#(
    parameter int PLL_CYC = `PLL_CYC
) (
    // Local clock and reset.
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    input  wire logic ce_in,
    // Status towards local logic.
    output logic      pll_locked_out,
    output logic      cfg_active_out,
    // Link.
    sram_cfg_if.dev   link
);
    logic [`CFG_W-1:0]  cfg_regs [`REG_NUM];
    logic               ce_meta_reg, ce_reg;
    logic               load_q_reg;
    logic [`CNT_W-1:0]  pll_cnt_reg;
    logic               locked_reg;
    logic [5:0]         rd_cnt_reg;
    logic [5:0]         hold_cnt_reg;
    logic [`ADDR_W-1:0] rd_addr_reg;
    logic               valid_reg;
    logic [`DQ_W-1:0]   dq_reg;
    logic [1:0]         stat_meta_reg, stat_reg;
    logic               load_fall;

    assign load_fall = ce_reg && !link.port_a_load_n && load_q_reg && !link.cfg_n;

    // Clock enable arrives from the local domain, so it is synchronised first.
    always_ff @(posedge link.link_clk or negedge link.dev_rst_n) begin
        if (!link.dev_rst_n) begin
            ce_meta_reg <= 1'b0;
            ce_reg      <= 1'b0;
        end else begin
            ce_meta_reg <= ce_in;
            ce_reg      <= ce_meta_reg;
        end
    end

    // Load strobe history for edge detection.
    always_ff @(posedge link.link_clk or negedge link.dev_rst_n) begin
        if (!link.dev_rst_n) begin
            load_q_reg <= 1'b1;
        end else if (ce_reg) begin
            load_q_reg <= link.port_a_load_n;
        end
    end

    // Lock timer restarts on reset and after a write to the loop settings.
    always_ff @(posedge link.link_clk or negedge link.dev_rst_n) begin
        if (!link.dev_rst_n) begin
            pll_cnt_reg <= '0;
            locked_reg  <= 1'b0;
        end else if (ce_reg) begin
            if (load_fall && !link.port_a_rw_n && link.addr == `PLL_IDX) begin
                pll_cnt_reg <= '0;
                locked_reg  <= 1'b0;
            end else if (pll_cnt_reg >= `CNT_W'(PLL_CYC - 1)) begin
                locked_reg  <= 1'b1;
            end else begin
                pll_cnt_reg <= pll_cnt_reg + `CNT_W'(1);
            end
        end
    end

    // Writes take only the low byte; upper lanes carry no meaning here.
    genvar gi;
    generate
        for (gi = 0; gi < `REG_NUM; gi++) begin : g_reg
            always_ff @(posedge link.link_clk or negedge link.dev_rst_n) begin
                if (!link.dev_rst_n) begin
                    cfg_regs[gi] <= `CFG_REG_RST;
                end else if (load_fall && !link.port_a_rw_n && link.addr == `ADDR_W'(gi)) begin
                    cfg_regs[gi] <= link.port_a_data[`CFG_W-1:0];
                end
            end
        end
    endgenerate

    // Read: data and valid rise together, fixed latency well inside the bound.
    always_ff @(posedge link.link_clk or negedge link.dev_rst_n) begin
        if (!link.dev_rst_n) begin
            rd_cnt_reg   <= '0;
            hold_cnt_reg <= '0;
            rd_addr_reg  <= '0;
            valid_reg    <= 1'b0;
            dq_reg       <= '0;
        end else if (ce_reg) begin
            if (load_fall && link.port_a_rw_n) begin
                rd_cnt_reg  <= 6'(`RD_LAT_CYC);
                rd_addr_reg <= link.addr;
            end else if (rd_cnt_reg == 6'h01) begin
                rd_cnt_reg <= '0;
                valid_reg  <= 1'b1;
                dq_reg     <= {{(`DQ_W-`CFG_W){1'b0}}, cfg_regs[rd_addr_reg[2:0]]};
            end else if (rd_cnt_reg != '0) begin
                rd_cnt_reg <= rd_cnt_reg - 6'h01;
            end
            if (!link.cfg_n || !valid_reg) begin
                hold_cnt_reg <= '0;
            end else if (hold_cnt_reg >= 6'(`RD_HOLD_CYC - 1)) begin
                valid_reg <= 1'b0;
                dq_reg    <= '0;
            end else begin
                hold_cnt_reg <= hold_cnt_reg + 6'h01;
            end
        end
    end

    assign link.port_a_read_valid = valid_reg;
    assign link.dev_dq_out        = dq_reg;
    assign link.dev_dq_oe         = valid_reg;
    assign link.port_b_data       = '0;

    // Status levels cross to the local clock through three flip-flops each.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stat_meta_reg  <= '0;
            stat_reg       <= '0;
            pll_locked_out <= 1'b0;
            cfg_active_out <= 1'b0;
        end else if (ce_in) begin
            stat_meta_reg  <= {~link.cfg_n, locked_reg};
            stat_reg       <= stat_meta_reg;
            pll_locked_out <= stat_reg[0];
            cfg_active_out <= stat_reg[1];
        end
    end
endmodule : sram_cfg_device

// ===== hw/sram_cfg_controller.sv
// Memory controller end: reset sequencing and configuration access timing.
`timescale 1ns/1ps
`include "sram_cfg_defines.svh"
module sram_cfg_controller
    import sram_cfg_pkg::*;
#(
    parameter int RSH_CYC      = `RSH_CYC,
    parameter int TSH_CYC      = `TSH_CYC,
    parameter int CFGH_PLL_CYC = `CFGH_PLL_CYC
) (
    // Clock, reset and freeze.
    input  wire logic               ref_clk_in,
    input  wire logic               rst_n_in,
    input  wire logic               ce_in,
    // Request from local logic.
    input  wire logic               req_valid_in,
    input  wire logic               req_write_in,
    input  wire logic [`ADDR_W-1:0] req_addr_in,
    input  wire logic [`CFG_W-1:0]  req_data_in,
    output logic                    req_ready_out,
    // Read answer and status.
    output logic                    rsp_valid_out,
    output logic [`CFG_W-1:0]       rsp_data_out,
    output logic                    active_ok_out,
    output logic                    jtag_ok_out,
    // Link.
    sram_cfg_if.ctl                 link
);
    localparam int CW = `CNT_W;

    ctl_state_e         state_reg;
    logic               link_clk_reg;
    logic               step;
    logic [CW-1:0]      boot_cnt_reg;
    logic               boot_ok_reg;
    logic [CW-1:0]      cnt_reg;
    logic [7:0]         gap_cnt_reg;
    logic [CW-1:0]      exit_lim_reg;
    logic               write_reg;
    logic               rd_pend_reg;
    logic [`ADDR_W-1:0] addr_hold_reg;
    logic [`CFG_W-1:0]  data_hold_reg;
    logic               rv_meta_reg, rv_sync_reg, rv_late_reg;
    logic [`CFG_W-1:0]  dq_meta_reg, dq_sync_reg;
    logic               dev_rst_n_reg, cfg_n_reg, load_n_reg, rw_n_reg, oe_reg;
    logic [`ADDR_W-1:0] addr_reg;

    // One link cycle is two reference cycles; outputs move on the low phase.
    assign step = ce_in && link_clk_reg;

    // Link clock divider.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link_clk_reg <= 1'b0;
        end else if (ce_in) begin
            link_clk_reg <= ~link_clk_reg;
        end
    end

    // Boot sequencing: short device reset, then both settle timers run.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            boot_cnt_reg  <= '0;
            dev_rst_n_reg <= 1'b0;
            boot_ok_reg   <= 1'b0;
            jtag_ok_out   <= 1'b0;
        end else if (step) begin
            if (!dev_rst_n_reg) begin
                if (boot_cnt_reg >= CW'(`DEV_RST_CYC - 1)) begin
                    dev_rst_n_reg <= 1'b1;
                    boot_cnt_reg  <= CW'(1);
                end else begin
                    boot_cnt_reg <= boot_cnt_reg + CW'(1);
                end
            end else if (!boot_ok_reg) begin
                boot_cnt_reg <= boot_cnt_reg + CW'(1);
                if (boot_cnt_reg >= CW'(TSH_CYC)) begin
                    jtag_ok_out <= 1'b1;
                end
                if (boot_cnt_reg >= CW'(RSH_CYC)) begin
                    boot_ok_reg <= 1'b1;
                end
            end
        end
    end

    // Read answer crosses through two flip-flops; valid gets a third so data has settled.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rv_meta_reg <= 1'b0;
            rv_sync_reg <= 1'b0;
            rv_late_reg <= 1'b0;
            dq_meta_reg <= '0;
            dq_sync_reg <= '0;
        end else if (ce_in) begin
            rv_meta_reg <= link.port_a_read_valid;
            rv_sync_reg <= rv_meta_reg;
            rv_late_reg <= rv_sync_reg;
            dq_meta_reg <= link.port_a_data[`CFG_W-1:0];
            dq_sync_reg <= dq_meta_reg;
        end
    end

    // Answer capture: data is taken a cycle after valid is first seen, never mid-change.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rsp_valid_out <= 1'b0;
            rsp_data_out  <= '0;
        end else if (ce_in) begin
            rsp_valid_out <= rd_pend_reg && rv_late_reg;
            if (rd_pend_reg && rv_late_reg) begin
                rsp_data_out <= dq_sync_reg;
            end
        end
    end

    // Command spacing, measured load to load and saturated when idle.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gap_cnt_reg <= 8'(`CFGD_CYC);
        end else if (step) begin
            if (state_reg == ST_SETUP && load_n_reg == 1'b0) begin
                gap_cnt_reg <= gap_cnt_reg;
            end else if (state_reg == ST_LOAD && cnt_reg == CW'(1)) begin
                gap_cnt_reg <= 8'h02;
            end else if (gap_cnt_reg < 8'(`CFGD_CYC)) begin
                gap_cnt_reg <= gap_cnt_reg + 8'h01;
            end
        end
    end

    // Sequencer: select, address, load strobe, release, exit wait.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg     <= ST_IDLE;
            cnt_reg       <= '0;
            exit_lim_reg  <= CW'(`CFGH_CYC);
            write_reg     <= 1'b0;
            rd_pend_reg   <= 1'b0;
            addr_hold_reg <= '0;
            data_hold_reg <= '0;
            cfg_n_reg     <= 1'b1;
            load_n_reg    <= 1'b1;
            rw_n_reg      <= 1'b1;
            oe_reg        <= 1'b0;
            addr_reg      <= '0;
            req_ready_out <= 1'b0;
            active_ok_out <= 1'b0;
        end else if (ce_in) begin
            if (rd_pend_reg && rv_late_reg) begin
                rd_pend_reg <= 1'b0;
            end
            case (state_reg)
                ST_IDLE: begin
                    req_ready_out <= boot_ok_reg;
                    active_ok_out <= boot_ok_reg;
                    if (req_ready_out && req_valid_in) begin
                        req_ready_out <= 1'b0;
                        active_ok_out <= 1'b0;
                        write_reg     <= req_write_in;
                        addr_hold_reg <= req_addr_in;
                        data_hold_reg <= req_data_in;
                        if (req_write_in && req_addr_in == `PLL_IDX) begin
                            exit_lim_reg <= CW'(CFGH_PLL_CYC);
                        end else if (req_write_in && req_addr_in == `ODT_IDX) begin
                            exit_lim_reg <= CW'(`CFGH_ODT_CYC);
                        end else begin
                            exit_lim_reg <= CW'(`CFGH_CYC);
                        end
                        cnt_reg   <= CW'(1);
                        state_reg <= ST_ENTER;
                    end
                end
                ST_ENTER: if (step) begin
                    cnt_reg <= cnt_reg + CW'(1);
                    if (cnt_reg > CW'(`CFGS_CYC)) begin // Covers the half cycle lost at take.
                        cfg_n_reg <= 1'b0;
                        cnt_reg   <= CW'(1);
                        state_reg <= ST_SETUP;
                    end
                end
                ST_SETUP: if (step) begin
                    cnt_reg <= cnt_reg + CW'(1);
                    if (cnt_reg >= CW'(`CFGA_CYC)) begin
                        addr_reg <= addr_hold_reg;
                        rw_n_reg <= ~write_reg;
                        oe_reg   <= write_reg;
                    end
                    if (cnt_reg >= CW'(`CLDS_CYC) && gap_cnt_reg >= 8'(`CFGD_CYC)) begin
                        load_n_reg  <= 1'b0;
                        rd_pend_reg <= ~write_reg;
                        cnt_reg     <= CW'(1);
                        state_reg   <= ST_LOAD;
                    end
                end
                ST_LOAD: if (step) begin
                    cnt_reg <= cnt_reg + CW'(1);
                    if (cnt_reg >= CW'(`CLDW_CYC)) begin
                        load_n_reg <= 1'b1;
                        cnt_reg    <= CW'(1);
                        state_reg  <= ST_HOLD;
                    end
                end
                ST_HOLD: if (step) begin
                    cnt_reg <= cnt_reg + CW'(1);
                    if (cnt_reg >= CW'(`CLDH_CYC)) begin
                        cfg_n_reg <= 1'b1;
                        oe_reg    <= 1'b0;
                        rw_n_reg  <= 1'b1;
                        cnt_reg   <= CW'(1);
                        state_reg <= ST_EXIT;
                    end
                end
                ST_EXIT: if (step) begin
                    cnt_reg <= cnt_reg + CW'(1);
                    if (cnt_reg >= exit_lim_reg) begin
                        rd_pend_reg <= 1'b0;
                        state_reg   <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Link pins come straight from flip-flops; only the low byte carries data.
    assign link.link_clk      = link_clk_reg;
    assign link.dev_rst_n     = dev_rst_n_reg;
    assign link.jtag_rst_n    = dev_rst_n_reg;
    assign link.cfg_n         = cfg_n_reg;
    assign link.port_a_load_n = load_n_reg;
    assign link.port_a_rw_n   = rw_n_reg;
    assign link.addr          = addr_reg;
    assign link.ctl_dq_out    = {{(`DQ_W-`CFG_W){1'b0}}, data_hold_reg};
    assign link.ctl_dq_oe     = oe_reg;
endmodule : sram_cfg_controller

// ===== bench/sram_cfg_chk.sv
// Timing checker for the configuration link between controller and device.
`timescale 1ns/1ps
`include "sram_cfg_defines.svh"
module sram_cfg_chk (
    // Link clock and device reset.
    input wire logic              link_clk,
    input wire logic              dev_rst_n,
    // Link signals from both ends.
    input wire logic              cfg_n,
    input wire logic              port_a_load_n,
    input wire logic              port_a_rw_n,
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic              ctl_dq_oe,
    input wire logic [`DQ_W-1:0]  dev_dq_out,
    input wire logic              dev_dq_oe,
    input wire logic              port_a_read_valid,
    input wire logic [`DQ_W-1:0]  port_b_data
);
    logic [7:0] sel_cnt_reg;
    logic [7:0] low_cnt_reg;
    logic [7:0] high_cnt_reg;
    logic [7:0] gap_cnt_reg;

    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!dev_rst_n);

    // Cycles with the select low; saturates so long selects cannot wrap.
    always_ff @(posedge link_clk or negedge dev_rst_n) begin
        if (!dev_rst_n) begin
            sel_cnt_reg <= 8'h00;
        end else begin
            sel_cnt_reg <= cfg_n ? 8'h00 : sel_cnt_reg + 8'(sel_cnt_reg != 8'hff);
        end
    end

    // Strobe width and strobe-to-release counts.
    always_ff @(posedge link_clk or negedge dev_rst_n) begin
        if (!dev_rst_n) begin
            low_cnt_reg  <= 8'h00;
            high_cnt_reg <= 8'h00;
        end else begin
            low_cnt_reg  <= port_a_load_n ? 8'h00 : low_cnt_reg + 8'(low_cnt_reg != 8'hff);
            high_cnt_reg <= (cfg_n || !port_a_load_n) ? 8'h00
                                                      : high_cnt_reg + 8'(high_cnt_reg != 8'hff);
        end
    end

    // Distance since the previous strobe; a low strobe with zero width count is a new one.
    always_ff @(posedge link_clk or negedge dev_rst_n) begin
        if (!dev_rst_n) begin
            gap_cnt_reg <= 8'hff;
        end else if (!port_a_load_n && low_cnt_reg == 8'h00) begin
            gap_cnt_reg <= 8'h01;
        end else begin
            gap_cnt_reg <= gap_cnt_reg + 8'(gap_cnt_reg != 8'hff);
        end
    end

    a_select_leads_load: assert property ($fell(port_a_load_n) |-> sel_cnt_reg >= 8'd32)
        else $error("load strobe came too soon after select");
    a_select_outlasts: assert property ($rose(cfg_n) |-> high_cnt_reg >= 8'd32)
        else $error("select released too soon after strobe");
    a_addr_settle: assert property (!cfg_n && sel_cnt_reg < 8'd16 |-> $stable(addr))
        else $error("address changed too early in select");
    a_load_width: assert property ($rose(port_a_load_n) |-> low_cnt_reg >= 8'd16)
        else $error("load strobe too short");
    a_cmd_spacing: assert property ($fell(port_a_load_n) |-> gap_cnt_reg >= 8'd80)
        else $error("commands too close together");
    a_read_latency: assert property ($fell(port_a_load_n) && port_a_rw_n |->
                                     ##[1:32] port_a_read_valid)
        else $error("read data late");
    a_read_hold: assert property ($rose(cfg_n) |-> ##[0:32] !port_a_read_valid)
        else $error("read data held too long");
    a_valid_align: assert property ($rose(port_a_read_valid) |->
                                    ##[0:2] (dev_dq_oe && !ctl_dq_oe))
        else $error("read valid not aligned with data");
    a_data_steady: assert property (port_a_read_valid && $past(port_a_read_valid) |->
                                    $stable(dev_dq_out))
        else $error("read data moved while valid");
    a_upper_quiet: assert property (dev_dq_oe |-> dev_dq_out[`DQ_W-1:8] == '0
                                    && port_b_data == '0)
        else $error("upper data bits not quiet");
    a_load_in_select: assert property (!port_a_load_n |-> !cfg_n)
        else $error("strobe outside select");
endmodule : sram_cfg_chk

// ===== bench/tb_top.sv
// Testbench joining controller and device and checking configuration traffic.
`timescale 1ns/1ps
`include "sram_cfg_defines.svh"
module tb_top;
    localparam int RSH = 200;
    localparam int TSH = 100;
    localparam int CPLL = 50;
    logic        ref_clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        ce_in = 1'b1;
    logic        req_valid_in = 1'b0;
    logic        req_write_in = 1'b0;
    logic [7:0]  req_addr_in = 8'h00;
    logic [7:0]  req_data_in = 8'h00;
    logic        req_ready_out, rsp_valid_out, active_ok_out, jtag_ok_out;
    logic        pll_locked_out, cfg_active_out;
    logic [7:0]  rsp_data_out;
    logic [7:0]  model [8];
    logic [7:0]  exp_rd = 8'h00;
    logic [31:0] seed = 32'ha82f_ffd1;
    int          failures = 0;
    int          cmp_count = 0;
    int          t, jt, ts;

    // Reference clock at 200 MHz; the link clock is divided from it by the controller.
    always #2.5 ref_clk_in = ~ref_clk_in;

    sram_cfg_if link_bus ();
    sram_cfg_controller #(.RSH_CYC(RSH), .TSH_CYC(TSH), .CFGH_PLL_CYC(CPLL))
        sram_cfg_controller_i (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_addr_in(req_addr_in),
        .req_data_in(req_data_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
        .rsp_data_out(rsp_data_out), .active_ok_out(active_ok_out), .jtag_ok_out(jtag_ok_out),
        .link(link_bus));
    sram_cfg_device #(.PLL_CYC(50)) sram_cfg_device_i (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .pll_locked_out(pll_locked_out), .cfg_active_out(cfg_active_out), .link(link_bus));
    sram_cfg_chk sram_cfg_chk_i (
        .link_clk(link_bus.link_clk), .dev_rst_n(link_bus.dev_rst_n), .cfg_n(link_bus.cfg_n),
        .port_a_load_n(link_bus.port_a_load_n), .port_a_rw_n(link_bus.port_a_rw_n),
        .addr(link_bus.addr), .ctl_dq_oe(link_bus.ctl_dq_oe), .dev_dq_out(link_bus.dev_dq_out),
        .dev_dq_oe(link_bus.dev_dq_oe), .port_a_read_valid(link_bus.port_a_read_valid),
        .port_b_data(link_bus.port_b_data));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs

    // Minimum link cycles the controller must idle after leaving configuration.
    function automatic int exit_wait(input logic wr, input logic [7:0] idx);
        if (wr && idx == `ODT_IDX) return `CFGH_ODT_CYC;
        if (wr && idx == `PLL_IDX) return CPLL;
        return `CFGH_CYC;
    endfunction : exit_wait

    task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out

    // The wire itself must carry the byte while read valid is up, upper bits quiet.
    always @(posedge link_bus.link_clk) begin
        if (link_bus.port_a_read_valid === 1'b1) begin
            check("wire byte", {10'h000, exp_rd}, link_bus.port_a_data);
        end
    end

    // One whole request; the optional freeze drops ce mid-operation to stress the pause path.
    task automatic do_op(input logic wr, input logic [7:0] a, input logic [7:0] d, input bit frz);
        bit got, seen;
        got = 1'b0;
        seen = 1'b0;
        @(posedge ref_clk_in);
        req_valid_in <= 1'b1;
        req_write_in <= wr;
        req_addr_in  <= a;
        req_data_in  <= d;
        exp_rd = model[a[2:0]];
        // Writes above the eight registers are dropped; reads alias on the low bits.
        if (wr && a < 8'h08) model[a[2:0]] = d;
        @(posedge ref_clk_in);
        req_valid_in <= 1'b0;
        @(negedge ref_clk_in);
        check("active after take", 18'h0_0000, 18'(active_ok_out));
        t = 1;
        ts = 20000;
        while (req_ready_out !== 1'b1 && t < 20000) begin
            @(posedge ref_clk_in);
            ce_in <= !(frz && t > 100 && t < 120);
            @(negedge ref_clk_in);
            t++;
            if (link_bus.cfg_n === 1'b0) ts = t;
            if (cfg_active_out === 1'b1) seen = 1'b1;
            if (rsp_valid_out === 1'b1) begin
                got = 1'b1;
                check("read byte", 18'(exp_rd), 18'(rsp_data_out));
            end
        end
        check("answer count", 18'(!wr), 18'(got));
        check("exit wait", 18'h0_0001, 18'(t - ts >= 2 * exit_wait(wr, a)));
        check("select mirrored", 18'h0_0001, 18'(seen));
        check("select idle", 18'h0_0000, 18'(cfg_active_out));
        check("active again", 18'h0_0001, 18'(active_ok_out));
        check("pll lock", 18'h0_0001, 18'(pll_locked_out));
    endtask : do_op

    // Hang guard sized well above the longest expected sequence.
    initial begin
        repeat (90000) @(posedge ref_clk_in);
        failures++;
        close_out();
    end

    initial begin
        foreach (model[i]) model[i] = `CFG_REG_RST;
        jt = 0;
        repeat (16) @(posedge ref_clk_in);
        check("select in reset", 18'h0_0001, 18'(link_bus.cfg_n));
        check("device reset", 18'h0_0000, 18'(link_bus.dev_rst_n));
        rst_n_in <= 1'b1;
        t = 0;
        while (req_ready_out !== 1'b1 && t < 5000) begin
            @(negedge ref_clk_in);
            t++;
            if (jtag_ok_out === 1'b1 && jt == 0) jt = t;
        end
        check("test port wait", 18'h0_0001, 18'(jt >= 2 * TSH));
        check("boot wait", 18'h0_0001, 18'(t >= 2 * RSH));
        check("boot lock", 18'h0_0001, 18'(pll_locked_out));
        check("ready after boot", 18'h0_0001, 18'(req_ready_out));
        // Corner cases: termination write, loop write, read-backs, a frozen read.
        do_op(1'b1, 8'h01, 8'ha5, 1'b0);
        do_op(1'b1, 8'h02, 8'h3c, 1'b0);
        do_op(1'b0, 8'h01, 8'h00, 1'b0);
        do_op(1'b0, 8'hfa, 8'h00, 1'b1);
        do_op(1'b0, 8'h07, 8'h00, 1'b0);
        for (int n = 0; n < 12; n++) begin
            seed = xs(seed);
            do_op(seed[0], seed[15:8], seed[23:16], 1'b0);
        end
        close_out();
    end
endmodule : tb_top
